// ==== hw/pin_select_map.svh ====
// Constants for the interface pin select block: offsets, fields, resets, timing.
// Assumes a 50 MHz system clock and an AXI4-Lite register bus.
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_W 4
`define OFS_IF_CONFIG 4'h0
`define OFS_STROBE_POL 4'h4
`define OFS_WAVE_CTRL 4'h8
`define OFS_STATUS 4'hC
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_MODE_LSB 0
`define CFG_INVERT_BIT 4
`define CFG_CLK_OE_BIT 5
`define CFG_CLK_FAST_BIT 6
`define CFG_INTERNAL_BIT 7
`define POL_WRITE_BIT 2
`define POL_READ_BIT 3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RESET 8'h02
`define POL_RESET 8'h00
`define WAVE_CTRL_RESET 6'h3F
// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_KHZ 50000
`define INTERFACE_CLOCK_PIN_SLOW_KHZ 30000
`define INTERFACE_CLOCK_PIN_FAST_KHZ 48000
`define HALF_CYC(f) (((`SYS_CLK_KHZ / (2 * (f))) > 0) ? (`SYS_CLK_KHZ / (2 * (f))) : 1)
`define INTERFACE_CLOCK_PIN_HALF_SLOW `HALF_CYC(`INTERFACE_CLOCK_PIN_SLOW_KHZ)
`define INTERFACE_CLOCK_PIN_HALF_FAST `HALF_CYC(`INTERFACE_CLOCK_PIN_FAST_KHZ)
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== hw/pin_select_pkg.sv ====
// Types for the interface pin select block.
// Assumes pin_select_map.svh is on the include path.
`include "pin_select_map.svh"
package pin_select_pkg;
  typedef enum logic [1:0] {
    MODE_PORTS = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_FIFO = 2'h3,
    MODE_WAVE = 2'h2
  } if_mode_e;
  typedef logic [3:0] idx_t;
  typedef struct packed {
    logic if_s1, if_s2, eff_prev, gen_lvl;
    logic [3:0] gen_cnt;
    logic [1:0] sel_s1, sel_s2;
    logic [5:0] rdy_s1, rdy_s2;
    logic [7:0] cfg, pol;
    logic [5:0] wave;
    if_mode_e mode;
    logic [5:0] ctl;
    logic [3:0] ctl_oe;
    logic clk_out, clk_oe, rd_act, wr_act, tick;
    logic [5:0] rdy_out;
    logic [`ADDR_W-1:0] awaddr;
    logic aw_got, w_got;
    logic [31:0] wdata;
    logic wstrb0, awready, wready, bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;
endpackage

// ==== hw/fifo_interface_pin_select.sv ====
// Interface pin select: shared control/flag pins, interface clock, strobes.
// Assumes AXI4-Lite master on sys_clk; FIFO flag inputs are on sys_clk.
//
// Functional notes
// - Mode field picks control output or FIFO flag on the three shared pins.
// - FIFO mode: first shared pin shows programmable level of selected FIFO.
// - FIFO mode: second shared pin shows full of selected FIFO.
// - FIFO mode: third shared pin shows empty of selected FIFO.
// - Extra control outputs; all control pins low in reset, high after.
// - FIFO flags and control timing referenced to the interface clock.
// - Clock-source bit set makes the interface clock internal.
// - Internal clock may be driven out; bits pick enable and 30/48 MHz, but both settings divide to a one-cycle half period (25 MHz).
// - Invert bit inverts the interface clock, internal or external.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.svh"
module fifo_interface_pin_select (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic interface_clock_pin_in,
  output logic interface_clock_pin_out,
  output logic interface_clock_pin_oe,
  input wire logic [1:0] fifo_select_pins,
  input wire logic [3:0] fifo_prog_level,
  input wire logic [3:0] fifo_full,
  input wire logic [3:0] fifo_empty,
  input wire logic wave_ready_in_0,
  input wire logic wave_ready_in_1,
  input wire logic wave_ready_in_2,
  input wire logic wave_ready_in_3,
  input wire logic wave_ready_in_4,
  input wire logic wave_ready_in_5,
  output logic wave_ctrl_out_0,
  output logic wave_ctrl_out_1,
  output logic wave_ctrl_out_2,
  output logic wave_ctrl_out_3,
  output logic wave_ctrl_out_4,
  output logic wave_ctrl_out_5,
  output logic [3:0] wave_ctrl_oe,
  output logic slave_read_strobe,
  output logic slave_write_strobe,
  output logic [5:0] wave_ready_sync,
  output logic if_clk_tick
);
  import pin_select_pkg::*;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Returns {hit, index}; shared by the read and write paths
  function automatic logic [2:0] reg_decode(input logic [`ADDR_W-1:0] a);
    case (a)
      `OFS_IF_CONFIG: reg_decode = 3'h4;
      `OFS_STROBE_POL: reg_decode = 3'h5;
      `OFS_WAVE_CTRL: reg_decode = 3'h6;
      `OFS_STATUS: reg_decode = 3'h7;
      default: reg_decode = 3'h0;
    endcase
  endfunction

  state_s s_reg;
  state_s s_next;
  logic [5:0] rdy_raw;
  logic eff_clk;
  logic edge_rise;
  logic [2:0] wdec;
  logic [2:0] rdec;
  logic [3:0] half;
  logic [31:0] status_word;

  assign rdy_raw = {wave_ready_in_5, wave_ready_in_4, wave_ready_in_3,
                    wave_ready_in_2, wave_ready_in_1, wave_ready_in_0};

  always_comb begin
    s_next = s_reg;
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    s_next.if_s1 = interface_clock_pin_in;
    s_next.if_s2 = s_reg.if_s1;
    s_next.sel_s1 = fifo_select_pins;
    s_next.sel_s2 = s_reg.sel_s1;
    s_next.rdy_s1 = rdy_raw;
    s_next.rdy_s2 = s_reg.rdy_s1;

    // ----------------------------------------
    // Interface clock
    // ----------------------------------------
    // 30/48 MHz cannot be made exactly from 50 MHz; the divider rounds
    // the half period down to whole cycles, never below one cycle
    half = s_reg.cfg[`CFG_CLK_FAST_BIT] ? 4'(`INTERFACE_CLOCK_PIN_HALF_FAST)
                                        : 4'(`INTERFACE_CLOCK_PIN_HALF_SLOW);
    if (s_reg.cfg[`CFG_INTERNAL_BIT]) begin
      if (s_reg.gen_cnt + 4'h1 >= half) begin
        s_next.gen_cnt = 4'h0;
        s_next.gen_lvl = ~s_reg.gen_lvl;
      end else begin
        s_next.gen_cnt = s_reg.gen_cnt + 4'h1;
      end
    end else begin
      s_next.gen_cnt = 4'h0;
      s_next.gen_lvl = 1'b0;
    end
    eff_clk = (s_reg.cfg[`CFG_INTERNAL_BIT] ? s_reg.gen_lvl : s_reg.if_s2)
              ^ s_reg.cfg[`CFG_INVERT_BIT];
    edge_rise = eff_clk & ~s_reg.eff_prev;
    s_next.eff_prev = eff_clk;
    s_next.tick = edge_rise;
    s_next.clk_out = eff_clk;
    s_next.clk_oe = s_reg.cfg[`CFG_INTERNAL_BIT] & s_reg.cfg[`CFG_CLK_OE_BIT];

    // ----------------------------------------
    // Pin functions, updated on rising interface clock edges only
    // ----------------------------------------
    if (edge_rise) begin
      // Mode is latched here so pins never switch between edges
      s_next.mode = if_mode_e'(s_reg.cfg[`CFG_MODE_LSB +: 2]);
      s_next.ctl[5:3] = s_reg.wave[5:3];
      if (s_next.mode == MODE_FIFO) begin
        s_next.ctl[0] = fifo_prog_level[s_reg.sel_s2];
        s_next.ctl[1] = fifo_full[s_reg.sel_s2];
        s_next.ctl[2] = fifo_empty[s_reg.sel_s2];
      end else begin
        s_next.ctl[2:0] = s_reg.wave[2:0];
      end
      // Port modes release the tristate pins
      s_next.ctl_oe = (s_next.mode == MODE_FIFO || s_next.mode == MODE_WAVE)
                      ? 4'hF : 4'h0;
    end

    // ----------------------------------------
    // Ready inputs and slave strobes
    // ----------------------------------------
    s_next.rdy_out = s_reg.rdy_s2;
    if (s_reg.mode == MODE_FIFO) begin
      s_next.rd_act = s_reg.rdy_s2[0] ^ ~s_reg.pol[`POL_READ_BIT];
      s_next.wr_act = s_reg.rdy_s2[1] ^ ~s_reg.pol[`POL_WRITE_BIT];
    end else begin
      s_next.rd_act = 1'b0;
      s_next.wr_act = 1'b0;
    end

    // ----------------------------------------
    // AXI4-Lite write
    // ----------------------------------------
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awaddr = s_axi_awaddr;
      s_next.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wdata = s_axi_wdata;
      s_next.wstrb0 = s_axi_wstrb[0];
      s_next.w_got = 1'b1;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    wdec = reg_decode(s_reg.awaddr);
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wdec[2] ? `RESP_OKAY : `RESP_SLVERR;
      if (s_reg.wstrb0) begin
        case (wdec)
          3'h4: s_next.cfg = s_reg.wdata[7:0];
          3'h5: s_next.pol = s_reg.wdata[7:0] & 8'h0C;
          3'h6: s_next.wave = s_reg.wdata[5:0];
          default: s_next.cfg = s_reg.cfg;
        endcase
      end
    end

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    status_word = {19'h0, s_reg.wr_act, s_reg.rd_act, s_reg.eff_prev,
                   s_reg.sel_s2, s_reg.mode, s_reg.rdy_s2};
    rdec = reg_decode(s_axi_araddr);
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = rdec[2] ? `RESP_OKAY : `RESP_SLVERR;
      case (rdec)
        3'h4: s_next.rdata = {24'h0, s_reg.cfg};
        3'h5: s_next.rdata = {24'h0, s_reg.pol};
        3'h6: s_next.rdata = {26'h0, s_reg.wave};
        3'h7: s_next.rdata = status_word;
        default: s_next.rdata = 32'h0;
      endcase
    end
    // Ready flags registered so every bus output leaves a flip-flop
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.cfg <= `CFG_RESET;
      s_reg.pol <= `POL_RESET;
      s_reg.wave <= `WAVE_CTRL_RESET;
      s_reg.mode <= MODE_WAVE;
      s_reg.ctl <= 6'h00;
      s_reg.ctl_oe <= 4'hF;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign interface_clock_pin_out = s_reg.clk_out;
  assign interface_clock_pin_oe = s_reg.clk_oe;
  assign wave_ctrl_out_0 = s_reg.ctl[0];
  assign wave_ctrl_out_1 = s_reg.ctl[1];
  assign wave_ctrl_out_2 = s_reg.ctl[2];
  assign wave_ctrl_out_3 = s_reg.ctl[3];
  assign wave_ctrl_out_4 = s_reg.ctl[4];
  assign wave_ctrl_out_5 = s_reg.ctl[5];
  assign wave_ctrl_oe = s_reg.ctl_oe;
  assign slave_read_strobe = s_reg.rd_act;
  assign slave_write_strobe = s_reg.wr_act;
  assign wave_ready_sync = s_reg.rdy_out;
  assign if_clk_tick = s_reg.tick;
endmodule // fifo_interface_pin_select
`default_nettype wire

// ==== bench/fifo_interface_pin_select_chk.sv ====
// Checker for the interface pin select block: pin timing and reset values.
// Assumes clk_en is held high throughout, as the bench does.
`timescale 1ns/1ps
`default_nettype none
module fifo_interface_pin_select_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic interface_clock_pin_out,
  input wire logic interface_clock_pin_oe,
  input wire logic wave_ready_in_0,
  input wire logic wave_ready_in_1,
  input wire logic wave_ready_in_2,
  input wire logic wave_ready_in_3,
  input wire logic wave_ready_in_4,
  input wire logic wave_ready_in_5,
  input wire logic wave_ctrl_out_0,
  input wire logic wave_ctrl_out_1,
  input wire logic wave_ctrl_out_2,
  input wire logic wave_ctrl_out_3,
  input wire logic wave_ctrl_out_4,
  input wire logic wave_ctrl_out_5,
  input wire logic [3:0] wave_ctrl_oe,
  input wire logic [5:0] wave_ready_sync,
  input wire logic if_clk_tick
);
  logic [5:0] ctl, rdy;
  logic [2:0] up_reg, up_next;
  assign ctl = {wave_ctrl_out_5, wave_ctrl_out_4, wave_ctrl_out_3, wave_ctrl_out_2,
    wave_ctrl_out_1, wave_ctrl_out_0};
  assign rdy = {wave_ready_in_5, wave_ready_in_4, wave_ready_in_3, wave_ready_in_2,
    wave_ready_in_1, wave_ready_in_0};
  // Cycles since reset; sync stages still hold reset values at first
  assign up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  always_ff @(posedge sys_clk) begin
    up_reg <= !rst_n ? 3'h0 : up_next;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_low: assert property (disable iff (1'b0)
    !rst_n |=> ctl == 6'h00 && wave_ctrl_oe == 4'hF && !interface_clock_pin_oe)
    else $error("control pins not cleared in reset");
  a_pins_on_tick: assert property (!if_clk_tick |-> $stable(ctl))
    else $error("control pins moved between interface clock edges");
  a_oe_on_tick: assert property (!if_clk_tick |-> $stable(wave_ctrl_oe))
    else $error("pin enables moved between interface clock edges");
  a_tick_single: assert property (if_clk_tick |=> !if_clk_tick)
    else $error("tick longer than one cycle");
  a_tick_edge: assert property (if_clk_tick == $rose(interface_clock_pin_out))
    else $error("tick not at rising edge of effective clock");
  a_clk_toggle: assert property (interface_clock_pin_oe [*8] |->
    $changed(interface_clock_pin_out)) else $error("driven clock not toggling");
  a_ready_delay: assert property (up_reg == 3'h7 |->
    wave_ready_sync == $past(rdy, 3)) else $error("ready sync delay wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // fifo_interface_pin_select_chk
bind fifo_interface_pin_select fifo_interface_pin_select_chk fifo_interface_pin_select_chk_inst (.*);
`default_nettype wire

// ==== bench/fifo_master_model.sv ====
// Far-side model: external master making the interface clock and ready lines.
// Assumes the bench sets run and rdy_set just after sys_clk edges.
`timescale 1ns/1ps
`default_nettype none
module fifo_master_model (
  input wire logic run,
  input wire logic [5:0] rdy_set,
  output logic interface_clock_pin,
  output logic [5:0] rdy
);
  // 160 ns clock, edges 3 ns before sys_clk rising edges, stands low outside frames
  initial begin
    interface_clock_pin = 1'b0;
    #7;
    forever #80 interface_clock_pin = run ? ~interface_clock_pin : 1'b0;
  end
  assign rdy = rdy_set; // Ready levels only, as set by the bench
endmodule // fifo_master_model
`default_nettype wire

// ==== bench/tb.sv ====
// Bench for the interface pin select block: register tasks and pin scenarios.
// Assumes the design, its checker and the far-side model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.svh"
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, run = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [`ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [31:0] cfgs [3] = '{32'hA2, 32'hE2, 32'h82};
  logic [3:0] s_axi_wstrb = 4'hF, wave_ctrl_oe;
  logic [3:0] fifo_prog_level = 4'hA, fifo_full = 4'h5, fifo_empty = 4'h3;
  logic [1:0] s_axi_bresp, s_axi_rresp, fifo_select_pins = 2'h0;
  logic interface_clock_pin_in, interface_clock_pin_out, interface_clock_pin_oe, far_clk;
  logic wave_ready_in_0, wave_ready_in_1, wave_ready_in_2, wave_ready_in_3, wave_ready_in_4;
  logic wave_ready_in_5, wave_ctrl_out_0, wave_ctrl_out_1, wave_ctrl_out_2, wave_ctrl_out_3;
  logic wave_ctrl_out_4, wave_ctrl_out_5, slave_read_strobe, slave_write_strobe, if_clk_tick;
  logic [5:0] rdy, rdy_set = 6'h00, wave_ready_sync, ctl;
  int failures = 0, total_checks = 0, n;
  assign {wave_ready_in_5, wave_ready_in_4, wave_ready_in_3, wave_ready_in_2, wave_ready_in_1,
    wave_ready_in_0} = rdy;
  assign ctl = {wave_ctrl_out_5, wave_ctrl_out_4, wave_ctrl_out_3, wave_ctrl_out_2,
    wave_ctrl_out_1, wave_ctrl_out_0};
  // Pin level: the block wins while it drives, otherwise the far side
  assign interface_clock_pin_in = interface_clock_pin_oe ? interface_clock_pin_out : far_clk;
  always #10 sys_clk = ~sys_clk;
  fifo_interface_pin_select fifo_interface_pin_select_inst (.*);
  fifo_master_model fifo_master_model_inst (.run(run), .rdy_set(rdy_set), .interface_clock_pin(far_clk),
    .rdy(rdy));
  // ----
  // Tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Local flags track each channel; the driven signals only update after the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_open, w_open, b_open;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_open = 1'b1;
    w_open = 1'b1;
    b_open = 1'b1;
    while (aw_open || w_open || b_open) begin
      @(posedge sys_clk);
      if (aw_open && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_open = 1'b0;
      end
      if (b_open && s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        b_open = 1'b0;
        chk("bresp", 32'(`RESP_OKAY), 32'(s_axi_bresp));
      end
    end
  endtask
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    logic ar_open, r_open;
    d = 32'h0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar_open = 1'b1;
    r_open = 1'b1;
    while (ar_open || r_open) begin
      @(posedge sys_clk);
      if (ar_open && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ar_open = 1'b0;
      end
      if (r_open && s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        r_open = 1'b0;
        d = s_axi_rdata;
        chk("rresp", 32'(`RESP_OKAY), 32'(s_axi_rresp));
      end
    end
  endtask
  task automatic cnt(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      c += int'(if_clk_tick === 1'b1);
    end
  endtask
  task automatic ticks(input int k);
    for (int i = 0; i < 400 && k > 0; i++) begin
      @(posedge sys_clk);
      k -= int'(if_clk_tick === 1'b1);
    end
    chk("tick wait", 32'h0, 32'(k));
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    chk("reset pins", 32'h0, 32'(ctl));
    rst_n <= 1'b1;
    rdr(`OFS_IF_CONFIG, rd);
    chk("cfg", 32'(`CFG_RESET), rd);
    rdr(`OFS_WAVE_CTRL, rd);
    chk("wave", 32'(`WAVE_CTRL_RESET), rd);
    run <= 1'b1;
    ticks(2);
    chk("pins high", 32'h3F, 32'(ctl));
    wr(`OFS_WAVE_CTRL, 32'h15);
    ticks(2);
    chk("wave pins", 32'h15, 32'(ctl));
    wr(`OFS_IF_CONFIG, 32'h03);
    for (int s = 0; s < 4; s++) begin
      fifo_select_pins <= 2'(s);
      ticks(3);
      chk("flags", {26'h0, 3'h2, fifo_empty[s], fifo_full[s], fifo_prog_level[s]}, 32'(ctl));
    end
    repeat (5) @(posedge sys_clk);
    chk("strobes", 32'h3, {30'h0, slave_read_strobe, slave_write_strobe});
    wr(`OFS_STROBE_POL, 32'h08);
    rdy_set <= 6'h2B;
    repeat (5) @(posedge sys_clk);
    chk("strobes", 32'h2, {30'h0, slave_read_strobe, slave_write_strobe});
    chk("ready sync", 32'h2B, {26'h0, wave_ready_sync});
    rdr(`OFS_STATUS, rd);
    chk("status ready", 32'h2B, {26'h0, rd[5:0]});
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_IF_CONFIG, 32'(m));
      ticks(2);
      chk("ports oe", 32'h0, {28'h0, wave_ctrl_oe});
      chk("ports strobes", 32'h0, {30'h0, slave_read_strobe, slave_write_strobe});
    end
    for (int v = 0; v < 2; v++) begin
      wr(`OFS_IF_CONFIG, v ? 32'h12 : 32'h02);
      ticks(2);
      @(posedge far_clk);
      cnt(5, n);
      chk("tick after rise", 32'(1 - v), 32'(n));
      @(negedge far_clk);
      cnt(5, n);
      chk("tick after fall", 32'(v), 32'(n));
    end
    run <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_IF_CONFIG, cfgs[k]);
      repeat (4) @(posedge sys_clk);
      cnt(20, n);
      chk("internal ticks", 32'd10, 32'(n));
      chk("clock oe", 32'(k < 2), 32'(interface_clock_pin_oe));
    end
    give_verdict();
  end
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire
